// ===== bench/cpu_instruction_execute_subset_bench.sv
// Self-checking bench for the instruction execution block.
// Assumes exec_map.vh on the include path and exec_props compiled first.
`timescale 1ns/1ps
`include "exec_map.vh"
module cpu_instruction_execute_subset_bench;
	reg         ref_clk = 1'h0;
	reg         rst = 1'h1;
	reg  [13:0] instr_word = 14'h0000;
	reg         instr_valid = 1'h0;
	reg  [7:0]  bus_addr = 8'h00;
	reg  [15:0] bus_wdata = 16'h0000;
	reg         bus_wr = 1'h0;
	reg         bus_rd = 1'h0;
	wire [15:0] bus_rdata;
	wire [14:0] fetch_addr;
	wire [7:0]  acc_out;
	wire [4:0]  status_out;
	wire        nop_cycle;
	wire        exec_done;
	integer     mismatches = 0;
	integer     checks = 0;
	integer     i;
	integer     n;
	reg  [12:0] e;
	reg  [7:0]  w;
	reg  [7:0]  fv;
	reg  [6:0]  fa;
	reg  [6:0]  pl;
	reg  [14:0] p;
	reg  [14:0] np;
	reg  [10:0] k;
	reg  [13:0] wd;
	reg  [5:0]  op;
	reg  [4:0]  st;
	reg  [3:0]  sp = 4'h0;
	reg         d;
	reg         c;
	reg         lit;
	reg         skp;
	// Operation exercised in slots 0 to 9 of the arithmetic and logic loop.
	function [5:0] op_of(input integer s);
		case (s)
			0: op_of = `OP_ADD_REG;
			1: op_of = `OP_ADD_CARRY_REG;
			2: op_of = `OP_AND_REG;
			3: op_of = `OP_OR_REG;
			4: op_of = `OP_ASR;
			5: op_of = `OP_COMPLEMENT;
			6: op_of = `OP_DECREMENT;
			7: op_of = `OP_INCREMENT;
			8: op_of = `OP_DEC_SKIP;
			default: op_of = `OP_INC_SKIP;
		endcase
	endfunction
	always #10 ref_clk = ~ref_clk;
	exec_unit i_dut (.ref_clk(ref_clk), .rst(rst), .instr_word(instr_word),
		.instr_valid(instr_valid), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fetch_addr(fetch_addr),
		.acc_out(acc_out), .status_out(status_out), .nop_cycle(nop_cycle),
		.exec_done(exec_done));
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input [63:0] nm, input [15:0] ev, input [15:0] got);
		checks = checks + 1;
		if (got !== ev) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %0s expected %h seen %h", nm, ev, got);
		end
	endtask
	task wr(input [7:0] ad, input [15:0] v);
		@(posedge ref_clk);
		bus_addr <= ad;
		bus_wdata <= v;
		bus_wr <= 1'h1;
		@(posedge ref_clk);
		bus_wr <= 1'h0;
	endtask
	task rdc(input [63:0] nm, input [7:0] ad, input [15:0] ev);
		@(posedge ref_clk);
		bus_addr <= ad;
		bus_rd <= 1'h1;
		@(posedge ref_clk);
		bus_rd <= 1'h0;
		#1 cmp(nm, ev, bus_rdata);
	endtask
	// Holds the word until its execute (and any nop cycle) has completed.
	task ex(input [13:0] iw);
		@(posedge ref_clk);
		instr_word <= iw;
		instr_valid <= 1'h1;
		for (n = 0; n < 40 && !(exec_done && !nop_cycle); n = n + 1)
			@(posedge ref_clk);
		if (n == 40) begin
			mismatches = mismatches + 1;
			end_of_test;
		end
		instr_valid <= 1'h0;
		@(posedge ref_clk);
		#1;
	endtask
	task pa(input nn, input [15:0] v, input [5:0] k6, input [15:0] ev);
		wr(nn ? `ADDR_POINTER1 : `ADDR_POINTER0, v);
		st = status_out;
		ex({`OP_POINTER_ADD, nn, k6});
		cmp("status", st, status_out);
		rdc("pointer", nn ? `ADDR_POINTER1 : `ADDR_POINTER0, ev);
	endtask
	// Result byte and flags of one arithmetic or logic operation.
	function [12:0] alu(input [5:0] o, input [7:0] a, input [7:0] b, input [4:0] s);
		reg [8:0] sm;
		reg [4:0] lo;
		reg [7:0] x;
		begin
			c = (o == `OP_ADD_CARRY_REG) & s[0];
			sm = a + b + c;
			lo = a[3:0] + b[3:0] + c;
			case (o)
				`OP_AND_REG, `OP_AND_LIT: x = a & b;
				`OP_OR_REG, `OP_OR_LIT: x = a | b;
				`OP_ASR: x = {b[7], b[7:1]};
				`OP_COMPLEMENT: x = ~b;
				`OP_DECREMENT, `OP_DEC_SKIP: x = b - 8'h01;
				`OP_INCREMENT, `OP_INC_SKIP: x = b + 8'h01;
				default: x = sm[7:0];
			endcase
			if (o == `OP_ADD_REG || o == `OP_ADD_LIT || o == `OP_ADD_CARRY_REG)
				s[1:0] = {lo[4], sm[8]};
			if (o == `OP_ASR)
				s[0] = b[0];
			if (o != `OP_DEC_SKIP && o != `OP_INC_SKIP)
				s[2] = (x == 8'h00);
			alu = {x, s};
		end
	endfunction
	initial begin
		i = $urandom(32'hF18A);
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		#1 cmp("status", `RST_STATUS, status_out);
		for (i = 0; i < 66; i = i + 1) begin
			op = (i % 11 == 10) ? ((i % 3 == 0) ? `OP_AND_LIT : (i % 3 == 1) ? `OP_OR_LIT :
				`OP_ADD_LIT) : op_of(i % 11);
			w = (i < 11) ? 8'hFF : $urandom;
			fv = (i < 11) ? 8'h01 : $urandom;
			fa = $urandom;
			d = $urandom;
			c = $urandom;
			st = {4'hC, c};
			wr(`ADDR_ACC, w);
			wr({1'h0, fa}, fv);
			wr(`ADDR_STATUS, st);
			lit = (op == `OP_ADD_LIT || op == `OP_AND_LIT || op == `OP_OR_LIT);
			e = alu(op, w, fv, st);
			skp = (op == `OP_DEC_SKIP || op == `OP_INC_SKIP) && e[12:5] == 8'h00;
			p = fetch_addr;
			ex(lit ? {op, fv} : {op, d, fa});
			np = p + (skp ? 15'h0002 : 15'h0001);
			cmp("acc", (lit || !d) ? e[12:5] : w, acc_out);
			cmp("status", e[4:0], status_out);
			cmp("fetch", np, fetch_addr);
			rdc("file", {1'h0, fa}, (!lit && d) ? e[12:5] : fv);
		end
		for (i = 0; i < 32; i = i + 1) begin
			fv = $urandom;
			fa = $urandom;
			wr({1'h0, fa}, fv);
			st = status_out;
			p = fetch_addr;
			ex({2'h1, i[4:3], i[2:0], fa});
			w = fv;
			if (!i[4])
				w[i[2:0]] = i[3];
			np = p + ((i[4] && fv[i[2:0]] == i[3]) ? 15'h0002 : 15'h0001);
			cmp("fetch", np, fetch_addr);
			cmp("status", st, status_out);
			rdc("file", {1'h0, fa}, w);
		end
		for (i = 0; i < 15; i = i + 1) begin
			w = $urandom;
			k = $urandom;
			pl = $urandom;
			p = $urandom;
			if (i < 5)
				k[8:0] = 9'h100;
			else if (i < 10)
				k[8:0] = 9'h0FF;
			wr(`ADDR_ACC, w);
			wr(`ADDR_PAGE_LATCH, pl);
			wr(`ADDR_PC, p);
			case (i % 5)
				0: {wd, np} = {5'h19, k[8:0], p + 15'h0001 + {{6{k[8]}}, k[8:0]}};
				1: {wd, np} = {`OP_BRANCH_ACC, p + 15'h0001 + w};
				2: {wd, np} = {`OP_CALL, k, pl[6:3], k};
				3: {wd, np} = {`OP_JUMP, k, pl[6:3], k};
				default: {wd, np} = {`OP_CALL_ACC, pl, w};
			endcase
			sp = sp + ((i % 5 == 2 || i % 5 == 4) ? 4'h1 : 4'h0);
			ex(wd);
			cmp("fetch", np, fetch_addr);
			rdc("stack", `ADDR_STACK_PTR, sp);
		end
		pa(1'h0, 16'hFFFE, 6'h05, 16'h0003);
		pa(1'h1, 16'h0002, 6'h20, 16'hFFE2);
		pa(1'h0, 16'h1234, 6'h1F, 16'h1253);
		fa = $urandom;
		wr({1'h0, fa}, 16'h00A5);
		wr(`ADDR_STATUS, `RST_STATUS);
		ex({`OP_CLEAR_REG, fa});
		cmp("zero", 1'h1, status_out[`ST_ZERO]);
		rdc("file", {1'h0, fa}, 16'h0000);
		wr(`ADDR_STATUS, `RST_STATUS);
		wr(`ADDR_ACC, 16'h005A);
		ex({`OP_CLEAR_ACC, 2'h3});
		cmp("acc", 8'h00, acc_out);
		cmp("zero", 1'h1, status_out[`ST_ZERO]);
		wr(`ADDR_STATUS, 16'h0004);
		ex(`OP_WDT_CLEAR);
		cmp("flags", 2'h3, status_out[4:3]);
		rdc("watchdog", `ADDR_WATCHDOG, 16'h0000);
		p = fetch_addr;
		repeat (12) @(posedge ref_clk);
		cmp("stall", p, fetch_addr);
		rdc("unmapped", 8'hF0, 16'h0000);
		end_of_test;
	end
endmodule // cpu_instruction_execute_subset_bench
bind exec_unit exec_props i_props (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
	.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rdata(bus_rdata), .fetch_addr(fetch_addr),
	.acc_out(acc_out), .nop_cycle(nop_cycle), .exec_done(exec_done));

// ===== bench/exec_props.sv
// Port checker for the instruction execution block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module exec_props (
	input wire        ref_clk,
	input wire        rst,
	input wire        instr_valid,
	input wire        bus_rd,
	input wire        bus_wr,
	input wire [15:0] bus_rdata,
	input wire [14:0] fetch_addr,
	input wire [7:0]  acc_out,
	input wire        nop_cycle,
	input wire        exec_done
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_done_spacing: assert property (exec_done |=> !exec_done [*3])
		else $error("exec_done closer than one instruction cycle");
	a_done_cause: assert property (exec_done |-> $past(instr_valid) || $past(nop_cycle))
		else $error("exec_done without an instruction");
	a_done_idle: assert property ((!instr_valid && !nop_cycle) [*5] |-> !exec_done)
		else $error("exec_done while stalled");
	a_acc_cause: assert property ($changed(acc_out) |-> exec_done || $past(bus_wr, 2))
		else $error("accumulator changed without cause");
	a_nop_start: assert property ($rose(nop_cycle) |-> exec_done)
		else $error("nop cycle began without an execute");
	a_nop_length: assert property ($rose(nop_cycle) |-> nop_cycle [*4] ##1 !nop_cycle)
		else $error("nop cycle not one instruction cycle long");
	a_nop_pc_hold: assert property ($rose(nop_cycle) |=> ##1 $stable(fetch_addr) [*2])
		else $error("fetch address moved in a nop cycle");
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
		else $error("read data outside its cycle");
	c_nop: cover property ($rose(nop_cycle));
	c_exec: cover property (exec_done && !nop_cycle);
	c_read: cover property (bus_rd ##1 bus_rdata != 16'h0000);
endmodule // exec_props

// ===== core/exec_map.vh
// Constants of the instruction execution block: opcodes, register map, flag positions.
// Assumes 14-bit instruction words and an 8-bit register bus address.
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// Oscillator cycles in one instruction cycle.
`define CLK_PER_INSTR     3'h4
`define PHASE_LAST        2'h3

// Opcode fields, compared against instruction bits 13:8.
`define OP_ADD_REG        6'h07
`define OP_ADD_CARRY_REG  6'h3D
`define OP_AND_REG        6'h05
`define OP_OR_REG         6'h04
`define OP_ASR            6'h37
`define OP_COMPLEMENT     6'h09
`define OP_DECREMENT      6'h03
`define OP_INCREMENT      6'h0A
`define OP_DEC_SKIP       6'h0B
`define OP_INC_SKIP       6'h0F
`define OP_ADD_LIT        6'h3E
`define OP_AND_LIT        6'h39
`define OP_OR_LIT         6'h38
// Compared against bits 13:7.
`define OP_CLEAR_REG      7'h03
`define OP_POINTER_ADD    7'h62
// Compared against bits 13:10.
`define OP_BIT_CLEAR      4'h4
`define OP_BIT_SET        4'h5
`define OP_SKIP_CLEAR     4'h6
`define OP_SKIP_SET       4'h7
// Compared against bits 13:9 and 13:11.
`define OP_REL_BRANCH     5'h19
`define OP_CALL           3'h4
`define OP_JUMP           3'h5
// Whole words; the clear-accumulator word ignores its two low bits.
`define OP_CLEAR_ACC      12'h040
`define OP_BRANCH_ACC     14'h000B
`define OP_CALL_ACC       14'h000A
`define OP_WDT_CLEAR      14'h0064

// Register bus map; file registers occupy 0x00 to 0x7F.
`define ADDR_FILE_TOP     8'h7F
`define ADDR_ACC          8'h80
`define ADDR_STATUS       8'h81
`define ADDR_PAGE_LATCH   8'h82
`define ADDR_PC           8'h83
`define ADDR_POINTER0     8'h84
`define ADDR_POINTER1     8'h85
`define ADDR_WATCHDOG     8'h86
`define ADDR_STACK_PTR    8'h87

// Status field positions.
`define ST_CARRY          0
`define ST_DIGIT_CARRY    1
`define ST_ZERO           2
`define ST_POWERDOWN_N    3
`define ST_TIMEOUT_N      4

// Reset values.
`define RST_STATUS        5'h18
`define RST_BYTE          8'h00
`define RST_PC            15'h0000
`define RST_POINTER       16'h0000

`endif

// ===== core/exec_unit.v
// Instruction execution block: accumulator, flags, file registers, pointers, counter and stack.
// Assumes instructions arrive synchronous to ref_clk and stand for a whole instruction cycle.
`timescale 1ns/1ps
`include "exec_map.vh"

module exec_unit #(
	parameter STACK_DEPTH = 16,
	parameter SP_W        = 4,
	parameter WDT_PRE_W   = 8,
	parameter WDT_W       = 8
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [13:0] instr_word,
	input  wire        instr_valid,
	input  wire [7:0]  bus_addr,
	input  wire [15:0] bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output reg  [15:0] bus_rdata,
	output reg  [14:0] fetch_addr,
	output reg  [7:0]  acc_out,
	output reg  [4:0]  status_out,
	output reg         nop_cycle,
	output reg         exec_done
);

	reg [1:0]             phase_r;
	reg [7:0]             acc_r;
	reg [4:0]             status_r;
	reg [6:0]             page_latch_r;
	reg [14:0]            pc_r;
	reg [15:0]            pointer_r [0:1];
	reg [7:0]             file_r [0:127];
	reg [14:0]            stack_r [0:STACK_DEPTH-1];
	reg [SP_W-1:0]        sp_r;
	reg [WDT_PRE_W-1:0]   wdt_pre_r;
	reg [WDT_W-1:0]       watchdog_counter_r;
	reg                   nop_pend_r;
	integer               i;

	wire                  exec_en = (phase_r == `PHASE_LAST);
	wire                  take    = exec_en && instr_valid && !nop_pend_r;
	wire [6:0]            f_addr  = instr_word[6:0];
	wire                  dest_f  = instr_word[7];
	wire [2:0]            bit_sel = instr_word[9:7];
	wire [7:0]            f_val   = file_r[f_addr];
	wire [14:0]           pc_next_addr = pc_r + 15'h0001;
	wire [14:0]           pc_skip_addr = pc_r + 15'h0002;
	wire                  wdt_expire   = exec_en && (&wdt_pre_r) && (&watchdog_counter_r);

	reg  [7:0]            res_nxt;
	reg                   wr_acc_nxt;
	reg                   wr_file_nxt;
	reg  [4:0]            status_nxt;
	reg  [14:0]           pc_nxt;
	reg                   two_cycle_nxt;
	reg                   push_nxt;
	reg                   ptr_wr_nxt;
	reg  [15:0]           ptr_sum_nxt;
	reg                   wdt_clr_nxt;
	reg  [9:0]            sum_v;

	// Returns {carry, digit carry, sum} of an 8-bit addition with carry in.
	function [9:0] add8;
		input [7:0] a;
		input [7:0] b;
		input       cin;
		reg   [8:0] s;
		reg   [4:0] lo;
		begin
			s     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			add8  = {s[8], lo[4], s[7:0]};
		end
	endfunction

	// Writes the zero flag from an 8-bit result.
	function [4:0] with_zero;
		input [4:0] st;
		input [7:0] r;
		begin
			with_zero = st;
			with_zero[`ST_ZERO] = (r == 8'h00);
		end
	endfunction

	// Adds or subtracts one, modulo 256.
	function [7:0] step8;
		input [7:0] v;
		input       up;
		begin
			step8 = up ? v + 8'h01 : v - 8'h01;
		end
	endfunction

	localparam [3:0]      BUS_FILE   = 4'h0;
	localparam [3:0]      BUS_ACC    = 4'h1;
	localparam [3:0]      BUS_STATUS = 4'h2;
	localparam [3:0]      BUS_PAGE   = 4'h3;
	localparam [3:0]      BUS_PC     = 4'h4;
	localparam [3:0]      BUS_PTR0   = 4'h5;
	localparam [3:0]      BUS_PTR1   = 4'h6;
	localparam [3:0]      BUS_WDT    = 4'h7;
	localparam [3:0]      BUS_SP     = 4'h8;
	localparam [3:0]      BUS_NONE   = 4'hF;

	// Decodes a register bus address; shared by the read and the write path.
	function [3:0] bus_sel;
		input [7:0] a;
		begin
			if (a <= `ADDR_FILE_TOP) begin
				bus_sel = BUS_FILE;
			end else if (a == `ADDR_ACC) begin
				bus_sel = BUS_ACC;
			end else if (a == `ADDR_STATUS) begin
				bus_sel = BUS_STATUS;
			end else if (a == `ADDR_PAGE_LATCH) begin
				bus_sel = BUS_PAGE;
			end else if (a == `ADDR_PC) begin
				bus_sel = BUS_PC;
			end else if (a == `ADDR_POINTER0) begin
				bus_sel = BUS_PTR0;
			end else if (a == `ADDR_POINTER1) begin
				bus_sel = BUS_PTR1;
			end else if (a == `ADDR_WATCHDOG) begin
				bus_sel = BUS_WDT;
			end else if (a == `ADDR_STACK_PTR) begin
				bus_sel = BUS_SP;
			end else begin
				bus_sel = BUS_NONE;
			end
		end
	endfunction

	wire [3:0]            bus_code = bus_sel(bus_addr);

	// Decodes the instruction word and works out every update of one execute edge.
	always @* begin
		res_nxt       = 8'h00;
		wr_acc_nxt    = 1'b0;
		wr_file_nxt   = 1'b0;
		status_nxt    = status_r;
		pc_nxt        = pc_next_addr;
		two_cycle_nxt = 1'b0;
		push_nxt      = 1'b0;
		ptr_wr_nxt    = 1'b0;
		ptr_sum_nxt   = pointer_r[instr_word[6]];
		wdt_clr_nxt   = 1'b0;
		sum_v         = 10'h000;
		if (instr_word[13:8] == `OP_ADD_LIT) begin
			sum_v      = add8(acc_r, instr_word[7:0], 1'b0);
			res_nxt    = sum_v[7:0];
			wr_acc_nxt = 1'b1;
			status_nxt[`ST_CARRY]       = sum_v[9];
			status_nxt[`ST_DIGIT_CARRY] = sum_v[8];
			status_nxt = with_zero(status_nxt, sum_v[7:0]);
		end else if (instr_word[13:8] == `OP_AND_LIT || instr_word[13:8] == `OP_OR_LIT) begin
			res_nxt    = (instr_word[13:8] == `OP_AND_LIT) ? (acc_r & instr_word[7:0]) :
				(acc_r | instr_word[7:0]);
			wr_acc_nxt = 1'b1;
			status_nxt = with_zero(status_r, res_nxt);
		end else if (instr_word[13:8] == `OP_AND_REG || instr_word[13:8] == `OP_OR_REG) begin
			res_nxt     = (instr_word[13:8] == `OP_AND_REG) ? (acc_r & f_val) :
				(acc_r | f_val);
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			status_nxt  = with_zero(status_r, res_nxt);
		end else if (instr_word[13:8] == `OP_ADD_REG || instr_word[13:8] == `OP_ADD_CARRY_REG) begin
			sum_v       = add8(acc_r, f_val, (instr_word[13:8] == `OP_ADD_CARRY_REG) &&
				status_r[`ST_CARRY]);
			res_nxt     = sum_v[7:0];
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			status_nxt[`ST_CARRY]       = sum_v[9];
			status_nxt[`ST_DIGIT_CARRY] = sum_v[8];
			status_nxt  = with_zero(status_nxt, sum_v[7:0]);
		end else if (instr_word[13:8] == `OP_ASR) begin
			res_nxt     = {f_val[7], f_val[7:1]};
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			status_nxt[`ST_CARRY] = f_val[0];
			status_nxt  = with_zero(status_nxt, res_nxt);
		end else if (instr_word[13:8] == `OP_COMPLEMENT) begin
			res_nxt     = ~f_val;
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			status_nxt  = with_zero(status_r, res_nxt);
		end else if (instr_word[13:8] == `OP_DECREMENT || instr_word[13:8] == `OP_INCREMENT) begin
			res_nxt     = step8(f_val, instr_word[13:8] == `OP_INCREMENT);
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			status_nxt  = with_zero(status_r, res_nxt);
		end else if (instr_word[13:8] == `OP_DEC_SKIP || instr_word[13:8] == `OP_INC_SKIP) begin
			res_nxt     = step8(f_val, instr_word[13:8] == `OP_INC_SKIP);
			wr_file_nxt = dest_f;
			wr_acc_nxt  = !dest_f;
			if (res_nxt == 8'h00) begin
				two_cycle_nxt = 1'b1;
				pc_nxt        = pc_skip_addr;
			end
		end else if (instr_word[13:7] == `OP_CLEAR_REG) begin
			wr_file_nxt = 1'b1;
			status_nxt[`ST_ZERO] = 1'b1;
		end else if (instr_word[13:2] == `OP_CLEAR_ACC) begin
			wr_acc_nxt  = 1'b1;
			status_nxt[`ST_ZERO] = 1'b1;
		end else if (instr_word[13:7] == `OP_POINTER_ADD) begin
			ptr_wr_nxt  = 1'b1;
			ptr_sum_nxt = pointer_r[instr_word[6]] +
				{{10{instr_word[5]}}, instr_word[5:0]};
		end else if (instr_word[13:10] == `OP_BIT_CLEAR || instr_word[13:10] == `OP_BIT_SET) begin
			res_nxt          = f_val;
			res_nxt[bit_sel] = (instr_word[13:10] == `OP_BIT_SET);
			wr_file_nxt      = 1'b1;
		end else if (instr_word[13:10] == `OP_SKIP_CLEAR || instr_word[13:10] == `OP_SKIP_SET) begin
			if (f_val[bit_sel] == (instr_word[13:10] == `OP_SKIP_SET)) begin
				two_cycle_nxt = 1'b1;
				pc_nxt        = pc_skip_addr;
			end
		end else if (instr_word[13:9] == `OP_REL_BRANCH) begin
			pc_nxt        = pc_next_addr + {{6{instr_word[8]}}, instr_word[8:0]};
			two_cycle_nxt = 1'b1;
		end else if (instr_word == `OP_BRANCH_ACC) begin
			pc_nxt        = pc_next_addr + {7'h00, acc_r};
			two_cycle_nxt = 1'b1;
		end else if (instr_word[13:11] == `OP_CALL || instr_word[13:11] == `OP_JUMP) begin
			pc_nxt        = {page_latch_r[6:3], instr_word[10:0]};
			push_nxt      = (instr_word[13:11] == `OP_CALL);
			two_cycle_nxt = 1'b1;
		end else if (instr_word == `OP_CALL_ACC) begin
			pc_nxt        = {page_latch_r, acc_r};
			push_nxt      = 1'b1;
			two_cycle_nxt = 1'b1;
		end else if (instr_word == `OP_WDT_CLEAR) begin
			wdt_clr_nxt = 1'b1;
			status_nxt[`ST_TIMEOUT_N]   = 1'b1;
			status_nxt[`ST_POWERDOWN_N] = 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			phase_r            <= 2'h0;
			acc_r              <= `RST_BYTE;
			status_r           <= `RST_STATUS;
			page_latch_r       <= 7'h00;
			pc_r               <= `RST_PC;
			pointer_r[0]       <= `RST_POINTER;
			pointer_r[1]       <= `RST_POINTER;
			sp_r               <= {SP_W{1'b0}};
			wdt_pre_r          <= {WDT_PRE_W{1'b0}};
			watchdog_counter_r <= {WDT_W{1'b0}};
			nop_pend_r         <= 1'b0;
			bus_rdata          <= 16'h0000;
			fetch_addr         <= `RST_PC;
			acc_out            <= `RST_BYTE;
			status_out         <= `RST_STATUS;
			nop_cycle          <= 1'b0;
			exec_done          <= 1'b0;
			for (i = 0; i < 128; i = i + 1) begin
				file_r[i] <= `RST_BYTE;
			end
			for (i = 0; i < STACK_DEPTH; i = i + 1) begin
				stack_r[i] <= `RST_PC;
			end
		end else begin
			phase_r   <= phase_r + 2'h1;
			exec_done <= exec_en && (take || nop_pend_r);
			bus_rdata <= 16'h0000;
			if (bus_rd) begin
				if (bus_code == BUS_FILE) begin
					bus_rdata <= {8'h00, file_r[bus_addr[6:0]]};
				end else if (bus_code == BUS_ACC) begin
					bus_rdata <= {8'h00, acc_r};
				end else if (bus_code == BUS_STATUS) begin
					bus_rdata <= {11'h000, status_r};
				end else if (bus_code == BUS_PAGE) begin
					bus_rdata <= {9'h000, page_latch_r};
				end else if (bus_code == BUS_PC) begin
					bus_rdata <= {1'b0, pc_r};
				end else if (bus_code == BUS_PTR0) begin
					bus_rdata <= pointer_r[0];
				end else if (bus_code == BUS_PTR1) begin
					bus_rdata <= pointer_r[1];
				end else if (bus_code == BUS_WDT) begin
					bus_rdata <= {{(16-WDT_W){1'b0}}, watchdog_counter_r};
				end else if (bus_code == BUS_SP) begin
					bus_rdata <= {{(16-SP_W){1'b0}}, sp_r};
				end
			end
			if (bus_wr) begin
				if (bus_code == BUS_FILE) begin
					file_r[bus_addr[6:0]] <= bus_wdata[7:0];
				end else if (bus_code == BUS_ACC) begin
					acc_r <= bus_wdata[7:0];
				end else if (bus_code == BUS_STATUS) begin
					status_r <= bus_wdata[4:0];
				end else if (bus_code == BUS_PAGE) begin
					page_latch_r <= bus_wdata[6:0];
				end else if (bus_code == BUS_PC) begin
					pc_r <= bus_wdata[14:0];
				end else if (bus_code == BUS_PTR0) begin
					pointer_r[0] <= bus_wdata;
				end else if (bus_code == BUS_PTR1) begin
					pointer_r[1] <= bus_wdata;
				end
			end
			if (exec_en) begin
				wdt_pre_r <= wdt_pre_r + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
				if (&wdt_pre_r) begin
					watchdog_counter_r <= watchdog_counter_r + {{(WDT_W-1){1'b0}}, 1'b1};
				end
				nop_pend_r <= take && two_cycle_nxt;
			end
			if (take) begin
				status_r <= status_nxt;
				pc_r     <= pc_nxt;
				if (wr_acc_nxt) begin
					acc_r <= res_nxt;
				end
				if (wr_file_nxt) begin
					file_r[f_addr] <= res_nxt;
				end
				if (ptr_wr_nxt) begin
					pointer_r[instr_word[6]] <= ptr_sum_nxt;
				end
				if (push_nxt) begin
					stack_r[sp_r] <= pc_next_addr;
					sp_r          <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
				end
				if (wdt_clr_nxt) begin
					wdt_pre_r          <= {WDT_PRE_W{1'b0}};
					watchdog_counter_r <= {WDT_W{1'b0}};
				end
			end
			// A timeout outranks the flag update of any instruction but a watchdog clear.
			if (wdt_expire && !(take && wdt_clr_nxt)) begin
				status_r[`ST_TIMEOUT_N] <= 1'b0;
			end
			// Outputs mirror the state one clock behind, except on an execute edge.
			fetch_addr <= take ? pc_nxt : pc_r;
			acc_out    <= (take && wr_acc_nxt) ? res_nxt : acc_r;
			status_out <= take ? status_nxt : status_r;
			nop_cycle  <= exec_en ? (take && two_cycle_nxt) : nop_pend_r;
		end
	end

endmodule // exec_unit
